// file: inc/adccal_pkg.sv
// Package for the converter calibration control block.
// Assumes a 200 MHz register clock and an AXI4-Lite master with 32-bit data.
package adccal_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_CAL_ENABLE = 8'h61;
   localparam logic [7:0] IDX_CAL_CONFIG = 8'h62;
   localparam logic [7:0] IDX_OFS_AVG = 8'h68;
   localparam logic [7:0] IDX_CAL_PROGRESS = 8'h6A;
   localparam logic [7:0] IDX_PIN_SETUP = 8'h6B;
   localparam logic [7:0] IDX_SW_TRIG = 8'h6C;
   localparam logic [7:0] IDX_LOW_POWER = 8'h6E;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h80;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h81;
   localparam int ADDR_W = 10;
   localparam int IDX_LSB = 2;
   // Reset values.
   localparam logic [7:0] RST_CAL_ENABLE = 8'h01;
   localparam logic [7:0] RST_CAL_CONFIG = 8'h01;
   localparam logic [2:0] RST_AVG_SEL = 3'h6;
   localparam logic [3:0] AVG_LOW_CONST = 4'h1;
   localparam logic [7:0] RST_PIN_SETUP = 8'h00;
   localparam logic [7:0] RST_SW_TRIG = 8'h01;
   localparam logic [7:0] RST_LOW_POWER = 8'h88;
   // Pin-select encodings.
   localparam logic [1:0] PSEL_FOREGROUND_COMPLETE = 2'h0;
   localparam logic [1:0] PSEL_STOPPED = 2'h1;
   localparam logic [1:0] PSEL_ALARM = 2'h2;
   // Interval timing: (2^k + 1) * 256 clock periods.
   localparam int LP_UNIT = 256;
   localparam int LP_CNT_W = 42;
   localparam logic [7:0] IRQ_FOREGROUND_COMPLETE_BIT = 8'h01;
   localparam logic [7:0] IRQ_STOPPED_BIT = 8'h02;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Calibration configuration fields.
   typedef struct packed {
      logic [3:0] rsvd;
      logic bg_offset_cal_enable;
      logic fg_offset_cal_enable;
      logic background_cal_enable;
      logic foreground_run_select;
   } adccal_cfg_t;
   // Low-power background fields.
   typedef struct packed {
      logic [2:0] sleep_interval_select;
      logic [1:0] settle_interval_select;
      logic rsvd;
      logic triggered_sleep_mode;
      logic low_power_bg_enable;
   } adccal_lp_t;
   // Calibration sequencer states.
   typedef enum logic [2:0] {
      ST_HOLD = 3'b000,
      ST_FG = 3'b001,
      ST_BG = 3'b010,
      ST_STOP = 3'b011,
      ST_SLEEP = 3'b100,
      ST_SETTLE = 3'b101,
      ST_DONE = 3'b110
   } adccal_state_t;
endpackage

// file: hdl/adccal_top.sv
// Calibration control: registers, sequencer, trigger select and status pin.
// Assumes synchronous inputs on aclk and a well-behaved AXI4-Lite master.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
// Contract
// - Bit 3: background offset cal, needs background.
// - Bit 2: foreground offset cal, needs foreground.
// - Bit 1 selects background calibration, reset off.
// - Bit 0: reset values, then optionally run foreground.
// - Averaging bits 6-4 reset 6; low nibble 0x1.
// - Stopped flag high at halt, low on resume.
// - Without background, stopped set after foreground.
// - Bit 0 foreground done; bits 4-2 code.
// - Pin select routes done, stopped, alarm, low.
// - Trigger select picks software bit or pin.
// - Software trigger bit acts as pin; reset 1.
// - Low-power register layout, reset 0x88.
// - Enable low holds reset; high runs calibration.
// - Low-power only while background calibration enabled.
// - Sleep timed, or until trigger goes low.
// - Intervals are (2^k+1) times 256 clocks.
module adccal_top import adccal_pkg::*; #(
   parameter int FG_RUN_CYCLES = 64,
   parameter int BG_PASS_CYCLES = 64,
   parameter int LP_UNIT_CYCLES = LP_UNIT
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Pins and core status
   input wire logic trigger_in_pin,
   input wire logic alarm_in,
   input wire logic [2:0] cal_code_in,
   output logic status_out_pin,
   output logic irq,
   // Core controls
   output logic cal_values_reset,
   output logic fg_cal_active,
   output logic bg_cal_active,
   output logic offset_cal_active,
   output logic core_sleep,
   output logic [2:0] offset_average_select
);
   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers.
   // Interval in cycles for a power-of-two exponent.
   function automatic logic [LP_CNT_W-1:0] lp_cycles(input int k);
      logic [LP_CNT_W-1:0] base;
      base = (LP_CNT_W'(1) << k) + LP_CNT_W'(1);
      return LP_CNT_W'(base * LP_CNT_W'(LP_UNIT_CYCLES));
   endfunction
   // Exponent of the sleep interval.
   function automatic int sleep_exp(input logic [2:0] s);
      case (s)
         3'h0: return 3;
         3'h1: return 15;
         3'h2: return 18;
         3'h3: return 21;
         3'h4: return 24;
         3'h5: return 27;
         3'h6: return 30;
         default: return 33;
      endcase
   endfunction
   // Exponent of the settle interval.
   function automatic int settle_exp(input logic [1:0] s);
      case (s)
         2'h0: return 3;
         2'h1: return 18;
         2'h2: return 21;
         default: return 24;
      endcase
   endfunction
   // Register index from a byte address.
   function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:IDX_LSB];
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Register storage.
   logic cal_enable_ff;
   adccal_cfg_t cfg_ff;
   logic avg_msb_ff;
   logic [2:0] avg_sel_ff;
   logic [2:0] pin_rsvd_ff;
   logic [1:0] pin_sel_ff;
   logic hw_trigger_select_ff;
   logic sw_trigger_bit_ff;
   adccal_lp_t lp_ff;
   logic [1:0] irq_status_ff;
   logic [1:0] irq_mask_ff;
   logic foreground_complete_ff;
   logic cal_stopped_ff;
   adccal_state_t state_ff;
   logic [LP_CNT_W-1:0] cnt_ff;
   // Write and read channel holding state.
   logic aw_ff;
   logic w_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic do_write;
   logic [7:0] widx;
   logic [7:0] wbyte;
   logic wmapped;
   logic active_trigger;
   logic foreground_complete_evt;
   logic stop_evt;

   assign do_write = aw_ff && w_ff && !bvalid_ff;
   assign widx = reg_idx(awaddr_ff);
   assign wbyte = wstrb_ff[0] ? wdata_ff[7:0] : 8'h00;
   assign wmapped = (widx == IDX_CAL_ENABLE) || (widx == IDX_CAL_CONFIG) ||
      (widx == IDX_OFS_AVG) || (widx == IDX_CAL_PROGRESS) || (widx == IDX_PIN_SETUP) ||
      (widx == IDX_SW_TRIG) || (widx == IDX_LOW_POWER) || (widx == IDX_IRQ_STATUS) ||
      (widx == IDX_IRQ_MASK);
   // Software bit or pin, whichever the select names.
   assign active_trigger = hw_trigger_select_ff ? trigger_in_pin : sw_trigger_bit_ff;
   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data are taken in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
      end else begin
         awready_ff <= !aw_ff && !awready_ff && awvalid;
         wready_ff <= !w_ff && !wready_ff && wvalid;
         if (awvalid && awready_ff) begin
            aw_ff <= 1'b1;
            awaddr_ff <= awaddr;
         end else if (do_write) begin
            aw_ff <= 1'b0;
         end
         if (wvalid && wready_ff) begin
            w_ff <= 1'b1;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
         end else if (do_write) begin
            w_ff <= 1'b0;
         end
      end
   end
   // Write response, one per completed write.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wmapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Control registers written by software; byte lane 0 only.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_enable_ff <= RST_CAL_ENABLE[0];
         cfg_ff <= adccal_cfg_t'(RST_CAL_CONFIG);
         avg_msb_ff <= 1'b0;
         avg_sel_ff <= RST_AVG_SEL;
         {pin_rsvd_ff, pin_sel_ff, hw_trigger_select_ff} <= RST_PIN_SETUP[5:0];
         sw_trigger_bit_ff <= RST_SW_TRIG[0];
         lp_ff <= adccal_lp_t'(RST_LOW_POWER);
         irq_mask_ff <= '0;
      end else if (do_write && wstrb_ff[0]) begin
         case (widx)
            IDX_CAL_ENABLE: cal_enable_ff <= wbyte[0];
            IDX_CAL_CONFIG: cfg_ff <= adccal_cfg_t'(wbyte);
            IDX_OFS_AVG: {avg_msb_ff, avg_sel_ff} <= wbyte[7:4];
            IDX_PIN_SETUP: {pin_rsvd_ff, pin_sel_ff, hw_trigger_select_ff} <= wbyte[5:0];
            IDX_SW_TRIG: sw_trigger_bit_ff <= wbyte[0];
            IDX_LOW_POWER: lp_ff <= adccal_lp_t'(wbyte);
            IDX_IRQ_MASK: irq_mask_ff <= wbyte[1:0];
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Calibration sequencer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_HOLD;
         cnt_ff <= '0;
      end else if (!cal_enable_ff) begin
         state_ff <= ST_HOLD;
         cnt_ff <= '0;
      end else begin
         case (state_ff)
            ST_HOLD: begin
               // Stored values are reset on entry; foreground runs if selected.
               cnt_ff <= LP_CNT_W'(FG_RUN_CYCLES);
               if (cfg_ff.foreground_run_select) begin
                  state_ff <= ST_FG;
               end else if (cfg_ff.background_cal_enable) begin
                  state_ff <= ST_BG;
               end else begin
                  state_ff <= ST_DONE;
               end
            end
            ST_FG: begin
               if (cnt_ff > LP_CNT_W'(1)) begin
                  cnt_ff <= cnt_ff - LP_CNT_W'(1);
               end else if (cfg_ff.background_cal_enable) begin
                  state_ff <= ST_BG;
                  cnt_ff <= LP_CNT_W'(BG_PASS_CYCLES);
               end else begin
                  state_ff <= ST_DONE;
               end
            end
            ST_BG: begin
               if (cnt_ff > LP_CNT_W'(1)) begin
                  cnt_ff <= cnt_ff - LP_CNT_W'(1);
               end
               if (lp_ff.low_power_bg_enable && cnt_ff <= LP_CNT_W'(1)) begin
                  state_ff <= ST_SLEEP;
                  cnt_ff <= lp_cycles(sleep_exp(lp_ff.sleep_interval_select));
               end else if (!lp_ff.low_power_bg_enable && !active_trigger) begin
                  state_ff <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (active_trigger) begin
                  state_ff <= ST_BG;
                  cnt_ff <= LP_CNT_W'(BG_PASS_CYCLES);
               end
            end
            ST_SLEEP: begin
               if (cnt_ff > LP_CNT_W'(1)) begin
                  cnt_ff <= cnt_ff - LP_CNT_W'(1);
               end
               if (lp_ff.triggered_sleep_mode ? !active_trigger : cnt_ff <= LP_CNT_W'(1)) begin
                  state_ff <= ST_SETTLE;
                  cnt_ff <= lp_cycles(settle_exp(lp_ff.settle_interval_select));
               end
            end
            ST_SETTLE: begin
               if (cnt_ff > LP_CNT_W'(1)) begin
                  cnt_ff <= cnt_ff - LP_CNT_W'(1);
               end else begin
                  state_ff <= ST_BG;
                  cnt_ff <= LP_CNT_W'(BG_PASS_CYCLES);
               end
            end
            ST_DONE: state_ff <= ST_DONE;
            default: state_ff <= ST_HOLD;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Progress flags and core controls.
   assign foreground_complete_evt = cal_enable_ff && !foreground_complete_ff &&
      state_ff != ST_HOLD && state_ff != ST_FG;
   assign stop_evt = cal_enable_ff && !cal_stopped_ff &&
      (state_ff == ST_STOP || state_ff == ST_DONE);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         foreground_complete_ff <= 1'b0;
         cal_stopped_ff <= 1'b0;
      end else begin
         foreground_complete_ff <= cal_enable_ff &&
            (foreground_complete_ff || foreground_complete_evt);
         cal_stopped_ff <= stop_evt || (cal_stopped_ff && cal_enable_ff &&
            state_ff != ST_BG);
      end
   end
   // Outputs to the converter cores.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_values_reset <= 1'b1;
         fg_cal_active <= 1'b0;
         bg_cal_active <= 1'b0;
         offset_cal_active <= 1'b0;
         core_sleep <= 1'b0;
      end else begin
         cal_values_reset <= state_ff == ST_HOLD;
         fg_cal_active <= state_ff == ST_FG;
         bg_cal_active <= state_ff == ST_BG;
         offset_cal_active <= (state_ff == ST_FG && cfg_ff.fg_offset_cal_enable) ||
            (state_ff == ST_BG && cfg_ff.bg_offset_cal_enable);
         core_sleep <= state_ff == ST_SLEEP;
      end
   end
   assign offset_average_select = avg_sel_ff;
   ////////////////////////////////////////////////////////////////////////////
   // Status pin: a single registered mux, so it never glitches.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_out_pin <= 1'b0;
      end else begin
         case (pin_sel_ff)
            PSEL_FOREGROUND_COMPLETE: status_out_pin <= foreground_complete_ff;
            PSEL_STOPPED: status_out_pin <= cal_stopped_ff;
            PSEL_ALARM: status_out_pin <= alarm_in;
            default: status_out_pin <= 1'b0;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky status, write one to clear, set wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_ff <= '0;
         irq <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == 0 && foreground_complete_evt) || (i == 1 && stop_evt)) begin
               irq_status_ff[i] <= 1'b1;
            end else if (do_write && wstrb_ff[0] && widx == IDX_IRQ_STATUS && wbyte[i]) begin
               irq_status_ff[i] <= 1'b0;
            end
         end
         irq <= |(irq_status_ff & irq_mask_ff);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else begin
         arready_ff <= !arready_ff && !rvalid_ff && arvalid;
         if (arvalid && arready_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= '0;
            case (reg_idx(araddr))
               IDX_CAL_ENABLE: rdata_ff[0] <= cal_enable_ff;
               IDX_CAL_CONFIG: rdata_ff[7:0] <= cfg_ff;
               IDX_OFS_AVG: rdata_ff[7:0] <= {avg_msb_ff, avg_sel_ff, AVG_LOW_CONST};
               IDX_CAL_PROGRESS: rdata_ff[4:0] <= {cal_code_in, cal_stopped_ff,
                  foreground_complete_ff};
               IDX_PIN_SETUP: rdata_ff[5:0] <= {pin_rsvd_ff, pin_sel_ff, hw_trigger_select_ff};
               IDX_SW_TRIG: rdata_ff[0] <= sw_trigger_bit_ff;
               IDX_LOW_POWER: rdata_ff[7:0] <= lp_ff;
               IDX_IRQ_STATUS: rdata_ff[1:0] <= irq_status_ff;
               IDX_IRQ_MASK: rdata_ff[1:0] <= irq_mask_ff;
               default: rresp_ff <= RESP_SLVERR;
            endcase
         end else if (rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end
   // Bus outputs straight from their flops.
   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
endmodule

// file: dv/adccal_props.sv
// Port checker for the calibration control block.
// Assumes it is bound into adccal_top and sees only its ports.
`timescale 1ns/1ps
module adccal_props import adccal_pkg::*; #(
   parameter int FG_RUN_CYCLES = 64
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus answers
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // Core controls
   input wire logic cal_values_reset,
   input wire logic fg_cal_active,
   input wire logic bg_cal_active,
   input wire logic offset_cal_active,
   input wire logic core_sleep,
   input wire logic [2:0] offset_average_select,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [15:0] fg_len_ff;
   ////////////////////////////////////////
   // Counts the cycles of the current foreground run.
   always_ff @(posedge aclk) begin
      if (!aresetn || !fg_cal_active) begin
         fg_len_ff <= 16'h0000;
      end else begin
         fg_len_ff <= fg_len_ff + 16'h0001;
      end
   end
   ////////////////////////////////////////
   // Held calibration keeps every core idle.
   property p_hold_idle;
      cal_values_reset |-> !(fg_cal_active || bg_cal_active || offset_cal_active || core_sleep);
   endproperty
   a_hold_idle: assert property (p_hold_idle) else $error("core busy while held");
   property p_fg_len;
      $fell(fg_cal_active) && !cal_values_reset |-> fg_len_ff == 16'(FG_RUN_CYCLES);
   endproperty
   a_fg_len: assert property (p_fg_len) else $error("foreground run length");
   property p_ofs_mode;
      offset_cal_active |-> fg_cal_active || bg_cal_active;
   endproperty
   a_ofs_mode: assert property (p_ofs_mode) else $error("offset cal alone");
   property p_one_mode;
      !(fg_cal_active && bg_cal_active);
   endproperty
   a_one_mode: assert property (p_one_mode) else $error("both modes active");
   property p_sleep_idle;
      core_sleep |-> !fg_cal_active && !bg_cal_active && !cal_values_reset;
   endproperty
   a_sleep_idle: assert property (p_sleep_idle) else $error("sleep while busy");
   property p_avg_write;
      !$stable(offset_average_select) |-> $rose(bvalid);
   endproperty
   a_avg_write: assert property (p_avg_write) else $error("average changed unasked");
   property p_b_stand;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
   property p_r_stand;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_r_stand: assert property (p_r_stand) else $error("read answer dropped");
   property p_err_zero;
      rvalid && rresp == RESP_SLVERR |-> rdata == 32'h00000000;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
   // Main scenarios.
   c_fg: cover property ($fell(fg_cal_active));
   c_sleep: cover property ($rose(core_sleep));
   c_err: cover property (rvalid && rresp == RESP_SLVERR);
   c_irq: cover property ($rose(irq));
endmodule
bind adccal_top adccal_props #(.FG_RUN_CYCLES(FG_RUN_CYCLES)) u_props (.aclk(aclk),
   .aresetn(aresetn), .bvalid(bvalid), .bready(bready), .bresp(bresp), .rvalid(rvalid),
   .rready(rready), .rdata(rdata), .rresp(rresp), .cal_values_reset(cal_values_reset),
   .fg_cal_active(fg_cal_active), .bg_cal_active(bg_cal_active),
   .offset_cal_active(offset_cal_active), .core_sleep(core_sleep),
   .offset_average_select(offset_average_select), .irq(irq));

// file: dv/adc_calibration_control_tb_top.sv
// Self-checking bench for the calibration control block.
// Assumes adccal_top with its bound checker; bready and rready stay high.
`timescale 1ns/1ps
module adc_calibration_control_tb_top import adccal_pkg::*;;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, trigger_in_pin, alarm_in, status_out_pin, irq;
   logic cal_values_reset, fg_cal_active, bg_cal_active, offset_cal_active, core_sleep;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [2:0] cal_code_in, offset_average_select;
   int checks = 0;
   int n_errors = 0;
   int n;
   logic [7:0] ri [7] = '{IDX_CAL_ENABLE, IDX_CAL_CONFIG, IDX_OFS_AVG, IDX_PIN_SETUP,
      IDX_SW_TRIG, IDX_LOW_POWER, IDX_IRQ_MASK};
   logic [7:0] rv [7] = '{8'h01, 8'h01, 8'h61, 8'h00, 8'h01, 8'h88, 8'h00};
   ////////////////////////////////////////
   adccal_top #(.FG_RUN_CYCLES(64), .BG_PASS_CYCLES(16), .LP_UNIT_CYCLES(1)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .trigger_in_pin(trigger_in_pin), .alarm_in(alarm_in), .cal_code_in(cal_code_in),
      .status_out_pin(status_out_pin), .irq(irq), .cal_values_reset(cal_values_reset),
      .fg_cal_active(fg_cal_active), .bg_cal_active(bg_cal_active),
      .offset_cal_active(offset_cal_active), .core_sleep(core_sleep),
      .offset_average_select(offset_average_select));
   // Clock of 5 ns.
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   ////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic lost(input string msg);
      n_errors++;
      $display("[FAIL] %0t %s timed out", $time, msg);
      report_and_stop();
   endtask
   // One write; address and data offered together, each released once taken.
   task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
      int i;
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (i == 50) lost("write");
      check(32'(bresp), 32'(er), "write response");
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
      int i;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (i == 50) lost("read");
      check(32'(rresp), 32'(er), "read response");
      check(rdata, exp, "read data");
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return fg_cal_active;
         1: return bg_cal_active;
         default: return core_sleep;
      endcase
   endfunction
   // Waits, bounded, for a core control to reach a level.
   task automatic await(input int w, input logic lvl, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge aclk);
         if (pick(w) === lvl) break;
      end
      if (i == lim) lost("wait");
   endtask
   // Reprograms the settings with calibration held, then restarts it.
   task automatic cal_run(input logic [7:0] c, input logic [7:0] lp);
      wr(IDX_CAL_ENABLE, 32'h0, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check(32'(cal_values_reset), 32'h1, "held");
      wr(IDX_CAL_CONFIG, 32'(c), RESP_OKAY);
      wr(IDX_LOW_POWER, 32'(lp), RESP_OKAY);
      wr(IDX_CAL_ENABLE, 32'h1, RESP_OKAY);
   endtask
   ////////////////////////////////////////
   // Main sequence.
   initial begin
      {awvalid, wvalid, arvalid, alarm_in} = 4'h0;
      {bready, rready, trigger_in_pin} = 3'h7;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      cal_code_in = 3'h5;
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check(32'(status_out_pin), 32'h0, "pin at start");
      for (int k = 0; k < 7; k++) rd(ri[k], 32'(rv[k]), RESP_OKAY);
      check(32'(offset_average_select), 32'h6, "average");
      $display("test reset values done");
      await(0, 0, 200);
      repeat (2) @(posedge aclk);
      rd(IDX_CAL_PROGRESS, 32'h17, RESP_OKAY);
      check(32'(irq), 32'h0, "masked irq");
      wr(IDX_IRQ_MASK, 32'h1, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check(32'(irq), 32'h1, "irq");
      rd(IDX_IRQ_STATUS, 32'h3, RESP_OKAY);
      wr(IDX_IRQ_STATUS, 32'h1, RESP_OKAY);
      repeat (2) @(posedge aclk);
      check(32'(irq), 32'h0, "irq cleared");
      rd(IDX_IRQ_STATUS, 32'h2, RESP_OKAY);
      wr(IDX_IRQ_MASK, 32'h0, RESP_OKAY);
      $display("test foreground done");
      for (int s = 0; s < 4; s++) begin
         for (int a = 0; a < 2; a++) begin
            alarm_in <= a[0];
            wr(IDX_PIN_SETUP, 32'(s * 2), RESP_OKAY);
            repeat (2) @(posedge aclk);
            check(32'(status_out_pin), (s == 2) ? 32'(a) : 32'(s != 3), "pin");
         end
      end
      wr(IDX_OFS_AVG, 32'hABCD0035, RESP_OKAY);
      rd(IDX_OFS_AVG, 32'h31, RESP_OKAY);
      check(32'(offset_average_select), 32'h3, "average");
      wr(8'h10, 32'h1, RESP_SLVERR);
      rd(8'h10, 32'h0, RESP_SLVERR);
      $display("test registers done");
      cal_run(8'h04, 8'h88);
      repeat (10) @(posedge aclk);
      check(32'(fg_cal_active | offset_cal_active), 32'h0, "skipped");
      rd(IDX_CAL_PROGRESS, 32'h17, RESP_OKAY);
      cal_run(8'h05, 8'h88);
      await(0, 1, 20);
      check(32'(offset_cal_active), 32'h1, "fg offset");
      await(0, 0, 100);
      $display("test offset done");
      wr(IDX_PIN_SETUP, 32'h2, RESP_OKAY);
      cal_run(8'h0A, 8'h88);
      await(1, 1, 200);
      check(32'(offset_cal_active), 32'h1, "bg offset");
      rd(IDX_CAL_PROGRESS, 32'h15, RESP_OKAY);
      trigger_in_pin <= 1'b0;
      repeat (5) @(posedge aclk);
      check(32'(bg_cal_active), 32'h1, "pin ignored");
      wr(IDX_SW_TRIG, 32'h0, RESP_OKAY);
      await(1, 0, 20);
      repeat (2) @(posedge aclk);
      check(32'(status_out_pin), 32'h1, "stopped pin");
      rd(IDX_CAL_PROGRESS, 32'h17, RESP_OKAY);
      wr(IDX_SW_TRIG, 32'h1, RESP_OKAY);
      await(1, 1, 20);
      repeat (2) @(posedge aclk);
      check(32'(status_out_pin), 32'h0, "resumed pin");
      wr(IDX_PIN_SETUP, 32'h3, RESP_OKAY);
      await(1, 0, 20);
      trigger_in_pin <= 1'b1;
      await(1, 1, 20);
      $display("test trigger done");
      cal_run(8'h02, 8'h01);
      await(2, 1, 400);
      n = 1;
      while (n < 200) begin
         @(posedge aclk);
         if (core_sleep !== 1'b1) break;
         n++;
      end
      check(32'(n), 32'h9, "sleep length");
      cal_run(8'h02, 8'h03);
      await(2, 1, 400);
      repeat (20) @(posedge aclk);
      check(32'(core_sleep), 32'h1, "trig sleep");
      trigger_in_pin <= 1'b0;
      await(2, 0, 10);
      trigger_in_pin <= 1'b1;
      cal_run(8'h01, 8'h01);
      await(0, 1, 20);
      await(0, 0, 100);
      repeat (40) @(posedge aclk);
      check(32'(core_sleep), 32'h0, "no bg sleep");
      $display("test low power done");
      report_and_stop();
   end
endmodule
